// file: hdl/usc_consts.vh
// Constants for the unipolar stepper step control block
`ifndef USC_CONSTS_VH
`define USC_CONSTS_VH
// Register byte offsets
`define USC_REG_CTRL     8'h00
`define USC_REG_STATUS   8'h04
`define USC_REG_STEPCNT  8'h08
// Control register fields
`define USC_CTRL_STEP    0
`define USC_CTRL_BRAKE   1
`define USC_CTRL_PINOFF  2
`define USC_CTRL_W       3
`define USC_CTRL_RST     3'h0
`define USC_CTRL_KEEP    3'h6
// Status register fields
`define USC_ST_ANGLE_LO  0
`define USC_ST_ANGLE_HI  3
`define USC_ST_MODE_LO   4
`define USC_ST_MODE_HI   5
`define USC_ST_STBY      6
`define USC_ST_FAULT     7
`define USC_ST_HOME      8
`define USC_ST_BUSY      9
// Angle index: 16 positions of 22.5 degrees
`define USC_ANG_W        4
`define USC_ANG_HOME     4'h2
`define USC_ANG_QTR      4'h4
`define USC_ANG_3QTR     4'hc
`define USC_STEP_FULL    4'h4
`define USC_STEP_HALF    4'h2
`define USC_STEP_QUARTER 4'h1
// Resolution codes: {sel_hi, sel_lo}
`define USC_MODE_STBY    2'h0
`define USC_MODE_FULL    2'h1
`define USC_MODE_HALF    2'h2
`define USC_MODE_QUARTER 2'h3
// Current ratios in percent
`define USC_PCT_W        7
`define USC_PCT_100      7'h64
`define USC_PCT_71       7'h47
`define USC_PCT_38       7'h26
`define USC_PCT_0        7'h00
// Startup wait after standby release
`define USC_STARTUP_NS   10000
`define USC_CLK_NS       8
`define USC_CNT_W        16
`endif

// file: hdl/usc_step_ctrl.v
// Step and direction control logic of a unipolar stepper driver
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.vh"

// Function
// RL1 - Step clock rising edge advances one step
// RL2 - Step clock falling edge changes nothing
// RL3 - Enable low puts motor outputs high impedance
// RL4 - Controller keeps enable low during supply ramps
// RL5 - Direction high clockwise, low counter-clockwise
// RL6 - Clockwise A leads B, else B leads
// RL7 - Angle reset high forces home angle
// RL8 - Controller holds angle reset during power-up
// RL9 - Home currents 100%, quarter step 71%
// RL10 - Angle reset drives home flag low
// RL11 - Mode selects choose full, half, quarter
// RL12 - Both selects low: standby, full step
// RL13 - Standby cuts internal bias current
// RL14 - Entering standby clears latched shutdowns
// RL15 - Fault latch cleared by standby or supply
// RL16 - Controller waits startup time after standby
// RL17 - Fault flag released normally, low on fault
// RL18 - Home flag low only at home angle
// RL19 - Brake keeps stepping, current held 100%
// RL20 - Steps 90, 45, 22.5 degrees, wrap 360
module usc_step_ctrl #(
    parameter STARTUP_CYCLES = (`USC_STARTUP_NS + `USC_CLK_NS - 1) / `USC_CLK_NS
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Controller pins
    input  wire        step_clock,
    input  wire        rotation_direction,
    input  wire        output_enable,
    input  wire        angle_reset,
    input  wire        brake,
    input  wire        step_resolution_sel_hi,
    input  wire        step_resolution_sel_lo,
    // Supply and fault detectors
    input  wire        drive_supply_good,
    input  wire        thermal_shutdown,
    input  wire        overcurrent_shutdown,
    // Motor phase drive
    output reg         out_a_pos,
    output reg         out_a_neg,
    output reg         out_b_pos,
    output reg         out_b_neg,
    output reg         out_oe,
    output reg  [6:0]  current_a_pct,
    output reg  [6:0]  current_b_pct,
    // Open-drain flags
    output reg         home_angle_flag_out,
    output reg         home_angle_flag_oe,
    output reg         fault_flag_out,
    output reg         fault_flag_oe,
    // Power state
    output reg         chopping_oscillator_en,
    output reg         bias_en,
    output reg         startup_busy
);

    // Cosine magnitude of angle index, quarter-step table
    function [`USC_PCT_W-1:0] cos_mag;
        input [`USC_ANG_W-1:0] idx;
        reg   [2:0]            m;
        reg   [2:0]            c;
        begin
            m = idx[2:0];
            c = idx[3] ? ((m == 3'h0) ? 3'h0 : 3'h0) : 3'h0;
            // Fold into distance from 0 or 180 degrees
            if (idx[3] == 1'b0) begin
                c = (idx[2:0] <= 3'h4) ? idx[2:0] : (3'h0 - idx[2:0]);
            end else begin
                c = (idx[2:0] <= 3'h4) ? idx[2:0] : (3'h0 - idx[2:0]);
            end
            case (c)
                3'h0:    cos_mag = `USC_PCT_100;
                3'h1:    cos_mag = `USC_PCT_100;
                3'h2:    cos_mag = `USC_PCT_71;
                3'h3:    cos_mag = `USC_PCT_38;
                default: cos_mag = `USC_PCT_0;
            endcase
        end
    endfunction

    // Cosine is negative strictly between 90 and 270 degrees
    function cos_neg;
        input [`USC_ANG_W-1:0] idx;
        begin
            cos_neg = (idx > `USC_ANG_QTR) && (idx < `USC_ANG_3QTR);
        end
    endfunction

    // Final ratio: half, full, brake push any nonzero level to 100%
    // A phase at zero stays at zero, so that winding stays off at 90 degrees
    function [`USC_PCT_W-1:0] ratio;
        input [`USC_PCT_W-1:0] mag;
        input                  force_full;
        begin
            if (force_full && (mag != `USC_PCT_0)) begin
                ratio = `USC_PCT_100;
            end else begin
                ratio = mag;
            end
        end
    endfunction

    // State
    reg  [`USC_ANG_W-1:0]   angle_q;       // Electrical angle index
    reg  [`USC_ANG_W-1:0]   angle_d;
    reg                     step_prev_q;   // Previous step clock level
    reg                     stby_prev_q;   // Standby level last cycle
    reg                     fault_q;       // Latched shutdown
    reg  [12:0]             startup_q;     // Startup countdown
    reg  [`USC_CTRL_W-1:0]  ctrl_q;        // Software control bits
    reg                     soft_step_q;   // Software step pulse
    reg  [`USC_CNT_W-1:0]   step_cnt_q;    // Accepted steps

    // Decoded inputs
    wire [1:0] sel      = {step_resolution_sel_hi, step_resolution_sel_lo};
    wire       standby  = (sel == `USC_MODE_STBY);             // RL12
    wire [1:0] mode     = standby ? `USC_MODE_FULL : sel;      // RL11 RL12
    wire       pin_rise = step_clock & ~step_prev_q &
                          ~ctrl_q[`USC_CTRL_PINOFF];           // RL1 RL2
    // The first cycle out of standby is refused too: the wait count loads on that edge
    wire       do_step  = (pin_rise | soft_step_q) & ~standby &
                          ~stby_prev_q & (startup_q == 13'h0);
    wire       brake_on = brake | ctrl_q[`USC_CTRL_BRAKE];
    wire       apb_setup = psel & ~penable;
    wire       apb_wr   = psel & penable & pwrite & pready;

    // Step size per resolution
    reg  [`USC_ANG_W-1:0] step_sz;
    always @* begin
        case (mode)
            `USC_MODE_HALF:    step_sz = `USC_STEP_HALF;       // RL20
            `USC_MODE_QUARTER: step_sz = `USC_STEP_QUARTER;    // RL20
            default:           step_sz = `USC_STEP_FULL;       // RL20
        endcase
    end

    // Next angle: reset to home, else step in chosen direction
    always @* begin
        angle_d = angle_q;
        if (angle_reset) begin
            angle_d = `USC_ANG_HOME;                           // RL7
        end else if (do_step) begin
            if (rotation_direction) begin
                angle_d = angle_q + step_sz;                   // RL5 RL20
            end else begin
                angle_d = angle_q - step_sz;                   // RL5 RL20
            end
        end
    end

    // Current targets from the next angle
    wire                  full_force = (mode != `USC_MODE_QUARTER) | brake_on;
    wire [`USC_ANG_W-1:0] b_idx      = angle_d - `USC_ANG_QTR;  // RL6
    wire [`USC_PCT_W-1:0] a_pct      = ratio(cos_mag(angle_d), full_force); // RL9 RL19
    wire [`USC_PCT_W-1:0] b_pct      = ratio(cos_mag(b_idx), full_force);   // RL9 RL19
    wire                  drive_on   = output_enable & ~standby;

    // Angle, step edge and step counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            angle_q     <= `USC_ANG_HOME;
            step_prev_q <= 1'b0;
            step_cnt_q  <= {`USC_CNT_W{1'b0}};
        end else begin
            angle_q     <= angle_d;
            step_prev_q <= step_clock;
            if (do_step && !angle_reset) begin
                step_cnt_q <= step_cnt_q + 1'b1;
            end
        end
    end

    // Fault latch, standby tracking and startup wait
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_q     <= 1'b0;
            stby_prev_q <= 1'b1;
            startup_q   <= 13'h0;
        end else begin
            stby_prev_q <= standby;
            // Set wins over the clear
            // Clear on entry to standby or on loss of the drive supply
            if ((thermal_shutdown | overcurrent_shutdown) & ~standby) begin
                fault_q <= 1'b1;
            end else if ((standby & ~stby_prev_q) | ~drive_supply_good) begin
                fault_q <= 1'b0;                               // RL14 RL15
            end
            // Wait count loads on the first cycle out of standby
            if (standby) begin
                startup_q <= 13'h0;
            end else if (stby_prev_q) begin
                startup_q <= STARTUP_CYCLES[12:0];
            end else if (startup_q != 13'h0) begin
                startup_q <= startup_q - 1'b1;
            end
        end
    end

    // Registered pin outputs
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_a_pos              <= 1'b0;
            out_a_neg              <= 1'b0;
            out_b_pos              <= 1'b0;
            out_b_neg              <= 1'b0;
            out_oe                 <= 1'b0;
            current_a_pct          <= `USC_PCT_100;
            current_b_pct          <= `USC_PCT_100;
            home_angle_flag_out    <= 1'b0;
            home_angle_flag_oe     <= 1'b1;
            fault_flag_out         <= 1'b0;
            fault_flag_oe          <= 1'b0;
            chopping_oscillator_en <= 1'b0;
            bias_en                <= 1'b0;
            startup_busy           <= 1'b0;
        end else begin
            // Phase polarity; outputs float when disabled
            out_a_pos <= drive_on & (a_pct != `USC_PCT_0) & ~cos_neg(angle_d); // RL3 RL6
            out_a_neg <= drive_on & (a_pct != `USC_PCT_0) & cos_neg(angle_d);  // RL3 RL6
            out_b_pos <= drive_on & (b_pct != `USC_PCT_0) & ~cos_neg(b_idx);   // RL3 RL6
            out_b_neg <= drive_on & (b_pct != `USC_PCT_0) & cos_neg(b_idx);    // RL3 RL6
            out_oe    <= drive_on;                                             // RL3 RL12
            current_a_pct <= a_pct;
            current_b_pct <= b_pct;
            // Open-drain flags pull low only when enabled
            // Pin value is always low; the enable alone drives the pin
            home_angle_flag_out <= 1'b0;
            home_angle_flag_oe  <= angle_reset | (angle_d == `USC_ANG_HOME);   // RL10 RL18
            fault_flag_out      <= 1'b0;
            fault_flag_oe       <= fault_q;                                    // RL17
            chopping_oscillator_en <= ~standby;                                // RL12
            bias_en             <= ~standby;                                   // RL13
            startup_busy        <= (startup_q != 13'h0) | (stby_prev_q & ~standby);
        end
    end

    // APB control register and software step pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q      <= `USC_CTRL_RST;
            soft_step_q <= 1'b0;
        end else begin
            soft_step_q <= 1'b0;
            if (apb_wr && (paddr == `USC_REG_CTRL)) begin
                // Step bit is a one-cycle pulse and is never stored
                ctrl_q      <= pwdata[`USC_CTRL_W-1:0] & `USC_CTRL_KEEP;
                soft_step_q <= pwdata[`USC_CTRL_STEP];
            end
        end
    end

    // APB answer: ready in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= apb_setup;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
            if (apb_setup) begin
                case (paddr)
                    `USC_REG_CTRL: begin
                        prdata[`USC_CTRL_W-1:0] <= ctrl_q;
                    end
                    `USC_REG_STATUS: begin
                        prdata[`USC_ST_ANGLE_HI:`USC_ST_ANGLE_LO] <= angle_q;
                        prdata[`USC_ST_MODE_HI:`USC_ST_MODE_LO]   <= sel;
                        prdata[`USC_ST_STBY]  <= standby;
                        prdata[`USC_ST_FAULT] <= fault_q;
                        prdata[`USC_ST_HOME]  <= (angle_q == `USC_ANG_HOME);
                        prdata[`USC_ST_BUSY]  <= (startup_q != 13'h0);
                    end
                    `USC_REG_STEPCNT: begin
                        prdata[`USC_CNT_W-1:0] <= step_cnt_q;
                    end
                    default: begin
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule // usc_step_ctrl
`default_nettype wire

// file: tb/usc_ctrl_model.sv
// Step clock source standing in for the external controller
`timescale 1ns/1ps
`default_nettype none
module usc_ctrl_model (
    // Clock and requests
    input  wire logic       pclk,
    input  wire logic       go,
    input  wire logic       slow,
    input  wire logic       hold,
    input  wire logic [4:0] n,
    // Pin and state
    output var  logic       step_clock,
    output var  logic       busy
);
    logic [4:0] left_q;  // Pulses still to send
    logic [1:0] cnt_q;   // Phase length counter
    initial begin
        step_clock = 1'b0;
        busy = 1'b0;
        left_q = 5'h00;
        cnt_q = 2'h0;
    end
    // One high and one low phase per step, longer when slow
    always @(posedge pclk) begin
        if (go && !busy) begin
            left_q <= n;
            busy <= (n != 5'h00);
            cnt_q <= 2'h0;
        end else if (busy && !hold) begin
            if (cnt_q != (slow ? 2'h2 : 2'h0)) begin
                cnt_q <= cnt_q + 2'h1;
            end else begin
                cnt_q <= 2'h0;
                step_clock <= !step_clock;
                if (step_clock) begin
                    left_q <= left_q - 5'h01;
                    busy <= (left_q != 5'h01);
                end
            end
        end
    end
endmodule // usc_ctrl_model
`default_nettype wire

// file: tb/usc_step_ctrl_assertions.sv
// Port checker for the stepper step control block
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.vh"
module usc_step_ctrl_chk (
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Inputs watched
    input wire logic       psel,
    input wire logic       step_clock,
    input wire logic       output_enable,
    input wire logic       angle_reset,
    input wire logic       brake,
    input wire logic       step_resolution_sel_hi,
    input wire logic       step_resolution_sel_lo,
    input wire logic       thermal_shutdown,
    input wire logic       overcurrent_shutdown,
    // Outputs watched
    input wire logic       out_a_pos,
    input wire logic       out_a_neg,
    input wire logic       out_b_pos,
    input wire logic       out_b_neg,
    input wire logic       out_oe,
    input wire logic       home_angle_flag_oe,
    input wire logic       fault_flag_oe,
    input wire logic       chopping_oscillator_en,
    input wire logic       bias_en,
    input wire logic       startup_busy,
    input wire logic [6:0] current_a_pct,
    input wire logic [6:0] current_b_pct
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic [1:0] sel = {step_resolution_sel_hi, step_resolution_sel_lo};  // Mode pins
    chk_oe_off: assert property (!output_enable |=> !out_oe) else $error("out_oe high with enable low");
    chk_stby_power: assert property (sel == `USC_MODE_STBY |=> !chopping_oscillator_en && !bias_en)
        else $error("oscillator or bias on in standby");
    chk_reset_home: assert property (angle_reset |=> home_angle_flag_oe) else $error("home flag off");
    chk_fault_set: assert property ((thermal_shutdown || overcurrent_shutdown) && sel != 2'h0 && $stable(sel)
        |-> ##[1:2] fault_flag_oe) else $error("fault flag not driven");
    chk_stby_clear: assert property ((sel == 2'h0 && !thermal_shutdown && !overcurrent_shutdown)[*2]
        |=> !fault_flag_oe) else $error("fault flag kept in standby");
    chk_home_qtr: assert property ((angle_reset && sel == 2'h3 && !brake && !startup_busy)[*2]
        |=> current_a_pct == `USC_PCT_71 && current_b_pct == `USC_PCT_71) else $error("home current wrong");
    chk_brake_full: assert property (brake[*2] |=> current_a_pct == 7'h00 || current_a_pct == `USC_PCT_100)
        else $error("brake ratio wrong");
    chk_step_leave: assert property ($rose(step_clock) && home_angle_flag_oe && !angle_reset && !startup_busy
        && sel != 2'h0 && $stable(sel) |=> !home_angle_flag_oe) else $error("step did not leave home");
    chk_fall_hold: assert property ($fell(step_clock) && $past(presetn) && !psel && !startup_busy
        && $stable({angle_reset, output_enable, brake, sel})
        |=> $stable({out_a_pos, out_a_neg, out_b_pos, out_b_neg, current_a_pct, current_b_pct}))
        else $error("falling step edge moved outputs");
endmodule // usc_step_ctrl_chk
bind usc_step_ctrl usc_step_ctrl_chk chk (.*);
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench for the stepper step control block
`timescale 1ns/1ps
`default_nettype none
`include "usc_consts.vh"
module tb;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, step_clock, rotation_direction = 1'b0, output_enable = 1'b0;
    logic        angle_reset = 1'b1, brake = 1'b0, step_resolution_sel_hi = 1'b0, step_resolution_sel_lo = 1'b0;
    logic        drive_supply_good = 1'b1, thermal_shutdown = 1'b0, overcurrent_shutdown = 1'b0;
    logic        out_a_pos, out_a_neg, out_b_pos, out_b_neg, out_oe, home_angle_flag_out, home_angle_flag_oe;
    logic        fault_flag_out, fault_flag_oe, chopping_oscillator_en, bias_en, startup_busy;
    logic [6:0]  current_a_pct, current_b_pct;
    logic        go = 1'b0, slow = 1'b0, model_busy;
    logic [4:0]  nstep = 5'h00;
    int          n_errors = 0, n_compared = 0;
    // Rows: phases {a+,a-,b+,b-}, mode, direction, steps, expected angle index from home
    // Slow stepping is used where the expected angle index is odd
    logic [15:0] rows [6] = '{16'h6616, 16'h941e, 16'h4a38, 16'h8810, 16'haf02, 16'h9c3f};
    usc_step_ctrl #(.STARTUP_CYCLES(4)) uut (.*);
    usc_ctrl_model ctl (.pclk(pclk), .go(go), .slow(slow), .hold(startup_busy), .n(nstep),
        .step_clock(step_clock), .busy(model_busy));
    always #4 pclk = ~pclk;
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // New mode, then silence until the startup wait is over
    task set_mode(input logic [1:0] m);
        {step_resolution_sel_hi, step_resolution_sel_lo} <= m;
        tick(2);
        while (startup_busy === 1'b1) tick(1);
    endtask
    task steps(input logic [4:0] n);
        go <= 1'b1; nstep <= n;
        tick(1);
        go <= 1'b0;
        tick(1);
        while (model_busy === 1'b1) tick(1);
        tick(2);
    endtask
    task finish_test;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        tick(5000);
        n_errors++;
        finish_test();
    end
    initial begin
        tick(16);
        presetn <= 1'b1; output_enable <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            angle_reset <= 1'b1; rotation_direction <= rows[i][9]; slow <= rows[i][0];
            set_mode(rows[i][11:10]);
            angle_reset <= 1'b0;
            tick(1);
            steps(rows[i][8:4]);
            apb(1'b0, `USC_REG_STATUS, 32'h0);
            chk("angle", rd[3:0], rows[i][3:0]);
            chk("home", home_angle_flag_oe, rows[i][3:0] == `USC_ANG_HOME);
            chk("phase", {out_a_pos, out_a_neg, out_b_pos, out_b_neg}, rows[i][15:12]);
        end
        // Home currents in quarter and half step, then brake while stepping
        angle_reset <= 1'b1;
        set_mode(`USC_MODE_QUARTER);
        chk("cur_b", current_b_pct, `USC_PCT_71);
        set_mode(`USC_MODE_HALF);
        chk("cur_a", current_a_pct, `USC_PCT_100);
        set_mode(`USC_MODE_QUARTER);
        angle_reset <= 1'b0; brake <= 1'b1; rotation_direction <= 1'b1;
        steps(5'h01);
        chk("brake_a", current_a_pct, `USC_PCT_100);
        brake <= 1'b0;
        tick(2);
        chk("cur_q", current_a_pct, `USC_PCT_38);
        output_enable <= 1'b0;
        tick(2);
        chk("oe", out_oe, 1'b0);
        output_enable <= 1'b1;
        tick(2);
        chk("oe", out_oe, 1'b1);
        // Fault latch cleared by standby, then by supply loss
        thermal_shutdown <= 1'b1; tick(1); thermal_shutdown <= 1'b0; tick(2);
        chk("fault", fault_flag_oe, 1'b1);
        {step_resolution_sel_hi, step_resolution_sel_lo} <= `USC_MODE_STBY;
        tick(3);
        chk("fault", fault_flag_oe, 1'b0);
        chk("osc", {chopping_oscillator_en, bias_en, out_oe}, 3'h0);
        set_mode(`USC_MODE_FULL);
        chk("osc", chopping_oscillator_en, 1'b1);
        overcurrent_shutdown <= 1'b1; tick(1); overcurrent_shutdown <= 1'b0; tick(2);
        chk("fault", fault_flag_oe, 1'b1);
        drive_supply_good <= 1'b0; tick(2); drive_supply_good <= 1'b1; tick(2);
        chk("fault", fault_flag_oe, 1'b0);
        chk("od_out", {home_angle_flag_out, fault_flag_out}, 2'h0);
        // Every accepted edge was counted; a mid-run reset clears state
        apb(1'b0, `USC_REG_STEPCNT, 32'h0);
        chk("stepcnt", rd, 32'h1a);
        presetn <= 1'b0;
        tick(2);
        chk("rst", {out_oe, home_angle_flag_oe, fault_flag_oe, bias_en, startup_busy}, 5'h08);
        chk("rst_cur", current_a_pct, `USC_PCT_100);
        presetn <= 1'b1;
        set_mode(`USC_MODE_FULL);
        // Unmapped address is refused and has no effect, mapped one is not
        apb(1'b1, 8'h0c, 32'h1);
        chk("slverr", err, 1'b1);
        apb(1'b1, `USC_REG_CTRL, 32'h5);
        apb(1'b0, `USC_REG_CTRL, 32'h0);
        chk("slverr", err, 1'b0);
        chk("ctrl", rd, 32'h4);
        apb(1'b0, `USC_REG_STEPCNT, 32'h0);
        chk("stepcnt", rd, 32'h1);
        finish_test();
    end
endmodule // tb
`default_nettype wire
